// ==== design/lbs_eval.sv ====
/*
 Ladder condition evaluator: executes one bit-logic instruction at a time,
 keeps the current execution condition and a stack of unused conditions.
 Assumes a sequencer on the same clock and a bit memory that answers a
 read one cycle after the request.
*/
// How it works
// - block_and_combine ANDs current condition with newest saved one.
// - block_or_combine ORs current condition with newest saved one.
// - Mid-line load pushes current condition, then restarts from the operand.
// - Only a mid-line load saves a condition; the first load just starts.
// - Block combines take no operand, so no bit read is issued.
// - Each combine pops the saved condition it used.
// - Buffer holds eight entries, enough for nine blocks combined at the end.
// - Combining right after each block keeps depth at one, no limit.
// - Inverted OR ORs the condition with the inverted operand bit.
// - Loads set the condition to the operand bit or its inverse.
// - AND and OR forms combine with the operand bit or its inverse.
// - Output writes the condition, inverted output writes its inverse.
// - Combines always use the two most recent conditions.
`timescale 1ns/10ps
module lbs_eval
	import lbs_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic scan_start_in,
	input wire logic instr_valid_in,
	input wire lbs_instr_type instr_in,
	input wire logic rd_data_in,
	output logic ready_out,
	output logic done_out,
	output logic rd_req_out,
	output logic [LBS_ADDR_W-1:0] rd_addr_out,
	output lbs_bitwr_type wr_out,
	output logic cond_out,
	output logic line_open_out,
	output logic overflow_out,
	output logic underflow_out
);
	typedef enum logic [1:0] {LBS_ST_IDLE, LBS_ST_READ, LBS_ST_CAPT} lbs_state_type;

	lbs_state_type state_reg, state_next;
	lbs_op_type op_reg, op_next;
	logic cond_reg, cond_next;
	logic line_open_reg, line_open_next;
	logic ready_reg, ready_next;
	logic done_reg, done_next;
	logic rd_req_reg, rd_req_next;
	logic [LBS_ADDR_W-1:0] rd_addr_reg, rd_addr_next;
	lbs_bitwr_type wr_reg, wr_next;
	logic ovf_reg, ovf_next;
	logic unf_reg, unf_next;
	logic push, pop, stack_top;
	logic [LBS_CNT_W-1:0] depth;
	logic accept;

	// ----------------------------------------------------------------
	// Save buffer
	// ----------------------------------------------------------------
	lbs_stack u_stack (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.clear_in(scan_start_in),
		.push_in(push),
		.pop_in(pop),
		.data_in(cond_reg),
		.top_out(stack_top),
		.count_out(depth)
	);

	assign accept = ready_reg && instr_valid_in && !scan_start_in;

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	// Scan start dominates so a stale condition never leaks across scans
	always_comb
	begin
		state_next = state_reg;
		op_next = op_reg;
		cond_next = cond_reg;
		line_open_next = line_open_reg;
		done_next = 1'b0;
		rd_req_next = 1'b0;
		rd_addr_next = rd_addr_reg;
		wr_next = wr_reg;
		wr_next.en = 1'b0;
		ovf_next = ovf_reg;
		unf_next = unf_reg;
		push = 1'b0;
		pop = 1'b0;
		if (scan_start_in)
		begin
			state_next = LBS_ST_IDLE;
			cond_next = LBS_COND_RST;
			line_open_next = 1'b0;
			ovf_next = 1'b0;
			unf_next = 1'b0;
		end
		else
		begin
			case (state_reg)
				LBS_ST_IDLE:
				begin
					if (accept)
					begin
						op_next = instr_in.op;
						case (instr_in.op)
							LBS_OP_LOAD_CONDITION, LBS_OP_LOAD_INVERTED_CONDITION:
							begin
								rd_req_next = 1'b1;
								rd_addr_next = instr_in.addr;
								state_next = LBS_ST_READ;
								// First load of a line saves nothing
								if (line_open_reg)
								begin
									ovf_next = ovf_reg | (depth == LBS_CNT_FULL);
									push = (depth != LBS_CNT_FULL);
								end
							end
							LBS_OP_AND, LBS_OP_AND_INV, LBS_OP_OR, LBS_OP_OR_INV:
							begin
								rd_req_next = 1'b1;
								rd_addr_next = instr_in.addr;
								state_next = LBS_ST_READ;
							end
							LBS_OP_BLOCK_AND_COMBINE, LBS_OP_BLOCK_OR_COMBINE:
							begin
								// No operand read for combines
								done_next = 1'b1;
								unf_next = unf_reg | (depth == LBS_CNT_EMPTY);
								pop = (depth != LBS_CNT_EMPTY);
								if (pop)
								begin
									cond_next = (instr_in.op == LBS_OP_BLOCK_AND_COMBINE) ?
										(cond_reg & stack_top) : (cond_reg | stack_top);
								end
							end
							LBS_OP_OUT, LBS_OP_OUT_INV:
							begin
								// Several outputs may share one condition; line closes
								wr_next.en = 1'b1;
								wr_next.addr = instr_in.addr;
								wr_next.data = (instr_in.op == LBS_OP_OUT) ? cond_reg : !cond_reg;
								line_open_next = 1'b0;
								done_next = 1'b1;
							end
							default: done_next = 1'b1;
						endcase
					end
				end
				LBS_ST_READ: state_next = LBS_ST_CAPT;
				LBS_ST_CAPT:
				begin
					state_next = LBS_ST_IDLE;
					done_next = 1'b1;
					case (op_reg)
						LBS_OP_LOAD_CONDITION, LBS_OP_LOAD_INVERTED_CONDITION:
						begin
							cond_next = rd_data_in ^
								(op_reg == LBS_OP_LOAD_INVERTED_CONDITION);
							line_open_next = 1'b1;
						end
						LBS_OP_AND: cond_next = cond_reg & rd_data_in;
						LBS_OP_AND_INV: cond_next = cond_reg & !rd_data_in;
						LBS_OP_OR: cond_next = cond_reg | rd_data_in;
						LBS_OP_OR_INV: cond_next = cond_reg | !rd_data_in;
						default: cond_next = cond_reg;
					endcase
				end
				default: state_next = LBS_ST_IDLE;
			endcase
		end
		ready_next = (state_next == LBS_ST_IDLE);
	end

	// Registers only; every output below is one of these
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			state_reg <= LBS_ST_IDLE;
			op_reg <= LBS_OP_NOP;
			cond_reg <= LBS_COND_RST;
			line_open_reg <= 1'b0;
			ready_reg <= 1'b0;
			done_reg <= 1'b0;
			rd_req_reg <= 1'b0;
			rd_addr_reg <= LBS_ADDR_RST;
			wr_reg <= '0;
			ovf_reg <= 1'b0;
			unf_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			op_reg <= op_next;
			cond_reg <= cond_next;
			line_open_reg <= line_open_next;
			ready_reg <= ready_next;
			done_reg <= done_next;
			rd_req_reg <= rd_req_next;
			rd_addr_reg <= rd_addr_next;
			wr_reg <= wr_next;
			ovf_reg <= ovf_next;
			unf_reg <= unf_next;
		end
	end

	assign ready_out = ready_reg;
	assign done_out = done_reg;
	assign rd_req_out = rd_req_reg;
	assign rd_addr_out = rd_addr_reg;
	assign wr_out = wr_reg;
	assign cond_out = cond_reg;
	assign line_open_out = line_open_reg;
	assign overflow_out = ovf_reg;
	assign underflow_out = unf_reg;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence s_accept_combine;
		accept && (instr_in.op == LBS_OP_BLOCK_AND_COMBINE ||
			instr_in.op == LBS_OP_BLOCK_OR_COMBINE);
	endsequence
	sequence s_accept_load;
		accept && (instr_in.op == LBS_OP_LOAD_CONDITION ||
			instr_in.op == LBS_OP_LOAD_INVERTED_CONDITION);
	endsequence

	property p_block_and;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		accept && instr_in.op == LBS_OP_BLOCK_AND_COMBINE && depth != LBS_CNT_EMPTY
		|=> cond_reg == ($past(cond_reg) & $past(stack_top)) && done_reg;
	endproperty
	a_block_and: assert property (p_block_and) else $error("block and result wrong");
	property p_block_or;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		accept && instr_in.op == LBS_OP_BLOCK_OR_COMBINE && depth != LBS_CNT_EMPTY
		|=> cond_reg == ($past(cond_reg) | $past(stack_top));
	endproperty
	a_block_or: assert property (p_block_or) else $error("block or result wrong");
	property p_push;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		s_accept_load and (line_open_reg && depth != LBS_CNT_FULL)
		|=> depth == $past(depth) + LBS_CNT_ONE && stack_top == $past(cond_reg);
	endproperty
	a_push: assert property (p_push) else $error("mid-line load did not save");
	property p_first_load;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		s_accept_load and !line_open_reg |=> depth == $past(depth);
	endproperty
	a_first_load: assert property (p_first_load) else $error("first load saved");
	property p_no_operand;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		s_accept_combine |=> (!rd_req_reg && ready_reg) ##1 (!rd_req_reg || $past(accept));
	endproperty
	a_no_operand: assert property (p_no_operand) else $error("combine read an operand");
	property p_pop;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		s_accept_combine and depth != LBS_CNT_EMPTY |=> depth == $past(depth) - LBS_CNT_ONE;
	endproperty
	a_pop: assert property (p_pop) else $error("combine did not pop");
	property p_capacity;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		depth <= LBS_CNT_FULL;
	endproperty
	a_capacity: assert property (p_capacity) else $error("buffer beyond depth");
	property p_load_value;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		s_accept_load ##1 (rd_req_reg && !scan_start_in) ##1 !scan_start_in
		|=> cond_reg == ($past(rd_data_in) ^ (op_reg == LBS_OP_LOAD_INVERTED_CONDITION))
			&& done_reg;
	endproperty
	a_load_value: assert property (p_load_value) else $error("load value wrong");
	property p_or_inv;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		state_reg == LBS_ST_CAPT && op_reg == LBS_OP_OR_INV && !scan_start_in
		|=> cond_reg == ($past(cond_reg) | !$past(rd_data_in));
	endproperty
	a_or_inv: assert property (p_or_inv) else $error("inverted or wrong");
	property p_output;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		accept && instr_in.op == LBS_OP_OUT_INV
		|=> wr_reg.en && wr_reg.data == !$past(cond_reg) ##1 (!wr_reg.en || $past(accept));
	endproperty
	a_output: assert property (p_output) else $error("output write wrong");
	property p_scan_clear;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		scan_start_in |=> depth == LBS_CNT_EMPTY && !overflow_out && !underflow_out;
	endproperty
	a_scan_clear: assert property (p_scan_clear) else $error("scan start not cleared");
endmodule

// ==== design/lbs_pkg.sv ====
/*
 Shared constants and types for the ladder block-stack evaluator.
 Assumes one clock domain; included by every design file by import.
*/
package lbs_pkg;
	// ----------------------------------------------------------------
	// Sizes and reset values
	// ----------------------------------------------------------------
	localparam int LBS_ADDR_W = 16;
	localparam int LBS_STACK_DEPTH = 8;
	localparam int LBS_CNT_W = 4;
	localparam logic [LBS_CNT_W-1:0] LBS_CNT_EMPTY = 4'h0;
	localparam logic [LBS_CNT_W-1:0] LBS_CNT_FULL = 4'h8;
	localparam logic [LBS_CNT_W-1:0] LBS_CNT_ONE = 4'h1;
	localparam logic LBS_COND_RST = 1'b0;
	localparam logic [LBS_ADDR_W-1:0] LBS_ADDR_RST = 16'h0000;

	// ----------------------------------------------------------------
	// Instruction codes
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		LBS_OP_NOP,
		LBS_OP_LOAD_CONDITION,
		LBS_OP_LOAD_INVERTED_CONDITION,
		LBS_OP_AND,
		LBS_OP_AND_INV,
		LBS_OP_OR,
		LBS_OP_OR_INV,
		LBS_OP_BLOCK_AND_COMBINE,
		LBS_OP_BLOCK_OR_COMBINE,
		LBS_OP_OUT,
		LBS_OP_OUT_INV
	} lbs_op_type;

	// Instruction as handed over by the sequencer
	typedef struct packed {
		lbs_op_type op;
		logic [LBS_ADDR_W-1:0] addr;
	} lbs_instr_type;

	// Bit write toward the io_bit_area
	typedef struct packed {
		logic en;
		logic [LBS_ADDR_W-1:0] addr;
		logic data;
	} lbs_bitwr_type;
endpackage

// ==== design/lbs_stack.sv ====
/*
 Save buffer of unused execution conditions, a flip-flop stack.
 Assumes the caller never pushes when full nor pops when empty.
*/
`timescale 1ns/10ps
module lbs_stack
	import lbs_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic clear_in,
	input wire logic push_in,
	input wire logic pop_in,
	input wire logic data_in,
	output logic top_out,
	output logic [LBS_CNT_W-1:0] count_out
);
	logic [LBS_STACK_DEPTH-1:0] mem_reg;
	logic [LBS_STACK_DEPTH-1:0] mem_next;
	logic [LBS_CNT_W-1:0] count_reg;
	logic [LBS_CNT_W-1:0] count_next;
	logic [LBS_CNT_W-1:0] top_idx;

	// ----------------------------------------------------------------
	// Entry storage
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < LBS_STACK_DEPTH; gi++)
		begin : g_entry
			// Only the slot at the fill level takes the new condition
			always_comb
			begin
				mem_next[gi] = mem_reg[gi];
				if (push_in && count_reg == LBS_CNT_W'(gi))
				begin
					mem_next[gi] = data_in;
				end
			end
		end
	endgenerate

	// Fill level; clear wins so a scan always starts empty
	always_comb
	begin
		count_next = count_reg;
		if (clear_in)
		begin
			count_next = LBS_CNT_EMPTY;
		end
		else if (push_in)
		begin
			count_next = count_reg + LBS_CNT_ONE;
		end
		else if (pop_in)
		begin
			count_next = count_reg - LBS_CNT_ONE;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			mem_reg <= '0;
			count_reg <= LBS_CNT_EMPTY;
		end
		else
		begin
			mem_reg <= mem_next;
			count_reg <= count_next;
		end
	end

	// Most recent entry; value is don't-care when empty
	assign top_idx = count_reg - LBS_CNT_ONE;
	assign top_out = mem_reg[top_idx[2:0]];
	assign count_out = count_reg;
endmodule

// ==== tb/lbs_bitmem.sv ====
/*
 Behavioural bit memory that stands in for the io_bit_area beside the evaluator.
 Assumes reads answer in the cycle after the request and writes land at the edge.
*/
`timescale 1ns/10ps
module lbs_bitmem
	import lbs_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic rd_req_in,
	input wire logic [LBS_ADDR_W-1:0] rd_addr_in,
	input wire lbs_bitwr_type wr_in,
	output logic rd_data_out
);
	// Only the low six address bits select a bit, so addresses alias
	logic mem [0:63];

	initial rd_data_out = 1'b0;

	// Answer stands one cycle only; otherwise toggle so a late sample misreads
	always @(posedge sys_clk_in)
	begin
		if (rd_req_in)
			rd_data_out <= #1 mem[rd_addr_in[5:0]];
		else
			rd_data_out <= #1 ~rd_data_out;
		if (wr_in.en)
			mem[wr_in.addr[5:0]] <= wr_in.data;
	end
endmodule

// ==== tb/tb_ladder_block_stack_eval.sv ====
/*
 Self-checking testbench for the ladder block-stack evaluator.
 Assumes lbs_pkg and the bit memory model are compiled before it.
*/
`timescale 1ns/10ps
module tb_ladder_block_stack_eval
	import lbs_pkg::*;
;
	logic sys_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic scan_start_in = 1'b0;
	logic instr_valid_in = 1'b0;
	lbs_instr_type instr_in = '0;
	logic rd_data_in;
	logic ready_out, done_out, rd_req_out, cond_out, line_open_out;
	logic overflow_out, underflow_out;
	logic [LBS_ADDR_W-1:0] rd_addr_out;
	lbs_bitwr_type wr_out;
	int n_mismatch = 0;
	int samples_checked = 0;
	int seed = 32'h16ad8e8a;
	// Reference state kept by the bench
	logic e_cond, e_line, e_ovf, e_unf;
	logic sq [$];

	// ------------------------------------------------------------
	// Clock, design and partner
	// ------------------------------------------------------------
	always #25 sys_clk_in = ~sys_clk_in;

	lbs_eval uut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .scan_start_in(scan_start_in),
		.instr_valid_in(instr_valid_in), .instr_in(instr_in), .rd_data_in(rd_data_in),
		.ready_out(ready_out), .done_out(done_out), .rd_req_out(rd_req_out),
		.rd_addr_out(rd_addr_out), .wr_out(wr_out), .cond_out(cond_out),
		.line_open_out(line_open_out), .overflow_out(overflow_out),
		.underflow_out(underflow_out));

	lbs_bitmem bm (.sys_clk_in(sys_clk_in), .rd_req_in(rd_req_out), .rd_addr_in(rd_addr_out),
		.wr_in(wr_out), .rd_data_out(rd_data_in));

	// ------------------------------------------------------------
	// Compare and closing tasks
	// ------------------------------------------------------------
	task chk1(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task chk16(input logic [LBS_ADDR_W-1:0] got, input logic [LBS_ADDR_W-1:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task end_sim;
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Bus cycles
	// ------------------------------------------------------------
	// Scan start clears everything; the bench model follows
	task scan;
		scan_start_in = 1'b1;
		@(posedge sys_clk_in);
		#1 scan_start_in = 1'b0;
		e_cond = 1'b0; e_line = 1'b0; e_ovf = 1'b0; e_unf = 1'b0;
		sq.delete();
		chk1(overflow_out | underflow_out | line_open_out, 1'b0);
	endtask

	// One instruction: offer it, predict the result, compare at done
	task exec(input lbs_op_type op, input logic [LBS_ADDR_W-1:0] a);
		int n;
		logic b, t, seen, e_wr, opnd;
		b = bm.mem[a[5:0]];
		seen = 1'b0;
		e_wr = 1'b0;
		// One edge passes so valid is never lowered and raised in one time step
		@(posedge sys_clk_in);
		#1 n = 0;
		while (ready_out !== 1'b1 && n < 20)
		begin
			@(posedge sys_clk_in);
			#1 n++;
		end
		chk1(ready_out, 1'b1);
		instr_valid_in = 1'b1;
		instr_in = '{op: op, addr: a};
		@(posedge sys_clk_in);
		#1 instr_valid_in = 1'b0;
		opnd = (op >= LBS_OP_LOAD_CONDITION && op <= LBS_OP_OR_INV);
		case (op)
			LBS_OP_LOAD_CONDITION, LBS_OP_LOAD_INVERTED_CONDITION:
			begin
				if (e_line && sq.size() == 8) e_ovf = 1'b1;
				else if (e_line) sq.push_back(e_cond);
				e_cond = (op == LBS_OP_LOAD_CONDITION) ? b : ~b;
				e_line = 1'b1;
			end
			LBS_OP_AND: e_cond = e_cond & b;
			LBS_OP_AND_INV: e_cond = e_cond & ~b;
			LBS_OP_OR: e_cond = e_cond | b;
			LBS_OP_OR_INV: e_cond = e_cond | ~b;
			LBS_OP_BLOCK_AND_COMBINE, LBS_OP_BLOCK_OR_COMBINE:
			begin
				if (sq.size() == 0) e_unf = 1'b1;
				else
				begin
					t = sq.pop_back();
					e_cond = (op == LBS_OP_BLOCK_AND_COMBINE) ? (e_cond & t) : (e_cond | t);
				end
			end
			LBS_OP_OUT, LBS_OP_OUT_INV:
			begin
				e_wr = (op == LBS_OP_OUT) ? e_cond : ~e_cond;
				e_line = 1'b0;
			end
			default: ;
		endcase
		n = 0;
		while (done_out !== 1'b1 && n < 8)
		begin
			if (rd_req_out === 1'b1)
			begin
				seen = 1'b1;
				chk16(rd_addr_out, a);
			end
			@(posedge sys_clk_in);
			#1 n++;
		end
		chk1(done_out, 1'b1);
		chk1(seen, opnd);
		chk1(cond_out, e_cond);
		chk1(line_open_out, e_line);
		chk1(overflow_out, e_ovf);
		chk1(underflow_out, e_unf);
		if (op == LBS_OP_OUT || op == LBS_OP_OUT_INV)
		begin
			chk1(wr_out.en, 1'b1);
			chk16(wr_out.addr, a);
			chk1(wr_out.data, e_wr);
			@(posedge sys_clk_in);
			#1 chk1(bm.mem[a[5:0]], e_wr);
		end
	endtask

	// Random address, full width, so aliasing in the memory is exercised
	function automatic logic [LBS_ADDR_W-1:0] ra();
		return LBS_ADDR_W'($random(seed));
	endfunction

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	lbs_op_type ex [12] = '{LBS_OP_LOAD_CONDITION, LBS_OP_OR, LBS_OP_LOAD_CONDITION,
		LBS_OP_OR_INV, LBS_OP_BLOCK_AND_COMBINE, LBS_OP_OUT, LBS_OP_LOAD_INVERTED_CONDITION,
		LBS_OP_AND_INV, LBS_OP_LOAD_CONDITION, LBS_OP_AND, LBS_OP_BLOCK_OR_COMBINE,
		LBS_OP_OUT_INV};

	initial
	begin
		int v;
		for (int i = 0; i < 64; i++)
			bm.mem[i] = 1'($random(seed));
		repeat (8) @(posedge sys_clk_in);
		chk1(ready_out, 1'b0);
		#1 rst_n_in = 1'b1;
		@(posedge sys_clk_in);
		#1 scan();
		// Two-block examples with both combine kinds, twice over
		repeat (2)
			foreach (ex[i])
				exec(ex[i], ra());
		$display("test examples done");
		// Ten blocks coded first: eight saved, tenth overflows
		exec(LBS_OP_LOAD_CONDITION, ra());
		for (int i = 0; i < 9; i++)
			exec(i[0] ? LBS_OP_LOAD_INVERTED_CONDITION : LBS_OP_LOAD_CONDITION, ra());
		for (int i = 0; i < 9; i++)
			exec(i[0] ? LBS_OP_BLOCK_OR_COMBINE : LBS_OP_BLOCK_AND_COMBINE, 16'h0000);
		$display("test deep buffer done");
		scan();
		// Combine right after each block: depth stays at one
		exec(LBS_OP_LOAD_CONDITION, ra());
		repeat (30)
		begin
			exec(LBS_OP_LOAD_INVERTED_CONDITION, ra());
			exec($random(seed) & 1 ? LBS_OP_OR : LBS_OP_AND_INV, ra());
			exec($random(seed) & 1 ? LBS_OP_BLOCK_OR_COMBINE : LBS_OP_BLOCK_AND_COMBINE, ra());
		end
		$display("test series done");
		// Random programs with a scan start now and then
		for (int i = 0; i < 300; i++)
		begin
			v = $random(seed);
			if (i % 25 == 0) scan();
			exec(lbs_op_type'(4'(v[3:0] % 11)), ra());
		end
		$display("test random done");
		end_sim();
	end

	// Watchdog, well beyond the expected few thousand cycles
	initial
	begin
		#2000000;
		n_mismatch++;
		end_sim();
	end
endmodule
